// file: hw/timer_waveform_double_buffer.sv
// waveform timer with double-buffered compare and cycle length registers
// assumes an AXI4-Lite master on aclk and inputs synchronous to aclk
//
// Operation
// - compare channels, and cycle length in 8-bit mode, sit behind written buffers
// - one buffer-valid flag per buffered register, set by a new buffer value
// - while valid: sync-busy set, writes are errors, active reads invalid
// - unlocked valid buffer copies to active at update point, then flag clears
// - set-register command 0x3 updates buffers regardless of lock_update
// - two-bit waveform select at bits 1:0 picks top and output kind
// - normal modes use cycle length as top in 8-bit, maximum otherwise
// - match frequency: first compare channel is top, toggle on match
// - normal frequency: toggle on each match, nothing on wraparound
// - normal pulse width: set on match, clear on wraparound
// - match pulse width: first compare channel top, set on match, clear on wrap
// - updates and overflow at top counting up, at zero counting down
// - waveform select writes apply at once, no sync-busy
// - invert enable inverts waveform output and capture trigger of its channel
// - driver control ignored while enabled, and guarded against writes
`timescale 1ns/100ps
module timer_waveform_double_buffer #(
	parameter int NUM_CH = 2,
	parameter int CW = 32
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite write
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// system
	input wire logic access_guard,
	input wire logic [NUM_CH-1:0] capture_trigger_in,
	output logic [NUM_CH-1:0] waveform_output,
	output logic [NUM_CH-1:0] capture_trigger,
	output logic overflow_event,
	output logic irq
);

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
			input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				r[8*b +: 8] = nw[8*b +: 8];
			end
		end
		return r;
	endfunction

	function automatic logic [CW-1:0] width_mask(input timer_pkg::count_mode_t m);
		logic [CW-1:0] r;
		r = '1;
		if (m == timer_pkg::count_8) begin
			r = CW'(8'hFF);
		end else if (m != timer_pkg::count_32) begin
			r = CW'(16'hFFFF);
		end
		return r;
	endfunction

	// bus holding registers
	logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
	logic [1:0] bresp_q, rresp_q;
	logic [31:0] rdata_q, wdata_q;
	logic [3:0] wstrb_q;
	logic [5:0] widx_q, ridx_q;

	// timer state
	timer_pkg::ctrl_t ctrl_q;
	logic [1:0] wave_q;
	logic [NUM_CH-1:0] inv_q;
	logic [NUM_CH-1:0] mask_q, cbv_q;
	logic [7:0] int_mask_q, int_flag_q;
	logic pbv_q;
	logic [CW-1:0] count_q, cycle_q, cycle_buf_q;
	logic [CW-1:0] cmp_q [NUM_CH];
	logic [CW-1:0] cmp_buf_q [NUM_CH];
	logic [NUM_CH-1:0] raw_q;
	logic ovf_q, irq_q;
	logic [NUM_CH-1:0] wo_q, cap_q;

	// write decode
	logic wr_go, wr_map, wr_guard, wr_ok, sw_upd;
	logic [31:0] wval;
	logic [NUM_CH-1:0] cmp_sel, cbuf_sel;
	logic [1:0] wr_resp;

	assign wr_go = !awready_q && !wready_q && !bvalid_q;
	assign wval = merge(32'(cycle_buf_q), wdata_q, wstrb_q);
	assign sw_upd = wr_ok && widx_q == timer_pkg::IDX_CTRL_SET && wstrb_q[0]
		&& wdata_q[timer_pkg::CTRLB_CMD_LSB +: 3] == timer_pkg::CMD_UPDATE;

	always_comb begin
		wr_map = 1'b0;
		wr_guard = 1'b0;
		cmp_sel = '0;
		cbuf_sel = '0;
		for (int i = 0; i < NUM_CH; i++) begin
			cmp_sel[i] = widx_q == timer_pkg::IDX_CMP0 + 6'(i);
			cbuf_sel[i] = widx_q == timer_pkg::IDX_CMP_BUF0 + 6'(i);
			if ((cmp_sel[i] || cbuf_sel[i]) && cbv_q[i]) begin
				wr_guard = 1'b1;
			end
		end
		if ((widx_q == timer_pkg::IDX_CYCLE || widx_q == timer_pkg::IDX_CYCLE_BUF) && pbv_q) begin
			wr_guard = 1'b1;
		end
		if (widx_q == timer_pkg::IDX_DRV && access_guard) begin
			wr_guard = 1'b1;
		end
		case (widx_q)
			timer_pkg::IDX_CTRL, timer_pkg::IDX_CTRL_CLR, timer_pkg::IDX_CTRL_SET,
			timer_pkg::IDX_INT_MASK, timer_pkg::IDX_INT_FLAG, timer_pkg::IDX_DRV,
			timer_pkg::IDX_WAVE, timer_pkg::IDX_CYCLE, timer_pkg::IDX_CYCLE_BUF: wr_map = 1'b1;
			default: wr_map = |cmp_sel || |cbuf_sel;
		endcase
		wr_resp = !wr_map ? timer_pkg::RESP_DECERR :
			wr_guard ? timer_pkg::RESP_SLVERR : timer_pkg::RESP_OKAY;
	end
	assign wr_ok = wr_go && wr_map && !wr_guard;

	// counter, top and event points
	logic [CW-1:0] msk, top;
	logic wrap, upd_hw;
	logic [NUM_CH-1:0] match, raw_d;

	always_comb begin
		msk = width_mask(ctrl_q.count_mode);
		if (wave_q[0]) begin
			top = cmp_q[0] & msk;
		end else if (ctrl_q.count_mode == timer_pkg::count_8) begin
			top = cycle_q & msk;
		end else begin
			top = msk;
		end
		wrap = ctrl_q.enable && (ctrl_q.count_down ? count_q == '0 : count_q == top);
		upd_hw = wrap;
		for (int i = 0; i < NUM_CH; i++) begin
			match[i] = ctrl_q.enable && count_q == (cmp_q[i] & msk);
			raw_d[i] = raw_q[i];
			case (timer_pkg::waveform_select_t'(wave_q))
				timer_pkg::normal_frequency, timer_pkg::match_frequency: begin
					if (match[i]) begin
						raw_d[i] = !raw_q[i];
					end
				end
				timer_pkg::normal_pulse_width, timer_pkg::match_pulse_width: begin
					if (wrap) begin
						raw_d[i] = 1'b0;
					end else if (match[i]) begin
						raw_d[i] = 1'b1;
					end
				end
				default: raw_d[i] = raw_q[i];
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			count_q <= '0;
		end else if (ctrl_q.enable) begin
			if (ctrl_q.count_down) begin
				count_q <= (count_q == '0) ? top : (count_q - CW'(1)) & msk;
			end else begin
				count_q <= (count_q == top) ? '0 : (count_q + CW'(1)) & msk;
			end
		end
	end

	// control, waveform select and driver control
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_q <= '0;
			wave_q <= timer_pkg::WAVE_RESET[1:0];
			inv_q <= '0;
		end else if (wr_ok) begin
			if (widx_q == timer_pkg::IDX_CTRL && wstrb_q[0]) begin
				ctrl_q.enable <= wdata_q[timer_pkg::CTRL_ENABLE_BIT];
				ctrl_q.count_mode <= timer_pkg::count_mode_t'(wdata_q[timer_pkg::CTRL_MODE_LSB +: 2]);
			end
			if (widx_q == timer_pkg::IDX_CTRL_CLR && wstrb_q[0]) begin
				if (wdata_q[timer_pkg::CTRLB_DOWN_BIT]) begin
					ctrl_q.count_down <= 1'b0;
				end
				if (wdata_q[timer_pkg::CTRLB_LOCK_BIT]) begin
					ctrl_q.lock_update <= 1'b0;
				end
			end
			if (widx_q == timer_pkg::IDX_CTRL_SET && wstrb_q[0]) begin
				if (wdata_q[timer_pkg::CTRLB_DOWN_BIT]) begin
					ctrl_q.count_down <= 1'b1;
				end
				if (wdata_q[timer_pkg::CTRLB_LOCK_BIT]) begin
					ctrl_q.lock_update <= 1'b1;
				end
			end
			// no synchroniser stage: the select acts on the next count step
			if (widx_q == timer_pkg::IDX_WAVE && wstrb_q[0]) begin
				wave_q <= wdata_q[1:0];
			end
			if (widx_q == timer_pkg::IDX_DRV && wstrb_q[0] && !ctrl_q.enable) begin
				inv_q <= wdata_q[NUM_CH-1:0];
			end
		end
	end
	// double buffering of compare channels and cycle length
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cbv_q <= '0;
			pbv_q <= 1'b0;
			cycle_q <= '0;
			cycle_buf_q <= '0;
			for (int i = 0; i < NUM_CH; i++) begin
				cmp_q[i] <= '0;
				cmp_buf_q[i] <= '0;
			end
		end else begin
			if (wr_ok && widx_q == timer_pkg::IDX_CYCLE_BUF
					&& ctrl_q.count_mode == timer_pkg::count_8) begin
				cycle_buf_q <= CW'(wval);
				pbv_q <= 1'b1;
			end else if (pbv_q && ((upd_hw && !ctrl_q.lock_update) || sw_upd)) begin
				cycle_q <= cycle_buf_q;
				pbv_q <= 1'b0;
			end else if (wr_ok && widx_q == timer_pkg::IDX_CYCLE) begin
				cycle_q <= CW'(merge(32'(cycle_q), wdata_q, wstrb_q));
			end
			for (int i = 0; i < NUM_CH; i++) begin
				if (wr_ok && cbuf_sel[i]) begin
					cmp_buf_q[i] <= CW'(merge(32'(cmp_buf_q[i]), wdata_q, wstrb_q));
					cbv_q[i] <= 1'b1;
				end else if (cbv_q[i] && ((upd_hw && !ctrl_q.lock_update) || sw_upd)) begin
					cmp_q[i] <= cmp_buf_q[i];
					cbv_q[i] <= 1'b0;
				end else if (wr_ok && cmp_sel[i]) begin
					cmp_q[i] <= CW'(merge(32'(cmp_q[i]), wdata_q, wstrb_q));
				end
			end
		end
	end

	// waveform outputs and capture trigger, inversion applied at the flop
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			raw_q <= '0;
			wo_q <= '0;
			cap_q <= '0;
			ovf_q <= 1'b0;
		end else begin
			raw_q <= raw_d;
			wo_q <= raw_d ^ inv_q;
			cap_q <= capture_trigger_in ^ inv_q;
			ovf_q <= wrap;
		end
	end

	// interrupt flags: hardware set wins over a same-cycle write-one clear
	logic [7:0] int_set;
	always_comb begin
		int_set = '0;
		int_set[timer_pkg::INT_OVF_BIT] = wrap;
		int_set[timer_pkg::INT_ERR_BIT] = wr_go && wr_map && wr_guard;
		int_set[timer_pkg::INT_MATCH_LSB +: NUM_CH] = match;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			int_flag_q <= '0;
			int_mask_q <= '0;
			irq_q <= 1'b0;
		end else begin
			if (wr_ok && widx_q == timer_pkg::IDX_INT_FLAG && wstrb_q[0]) begin
				int_flag_q <= (int_flag_q & ~wdata_q[7:0]) | int_set;
			end else begin
				int_flag_q <= int_flag_q | int_set;
			end
			if (wr_ok && widx_q == timer_pkg::IDX_INT_MASK && wstrb_q[0]) begin
				int_mask_q <= wdata_q[7:0];
			end
			irq_q <= |(int_flag_q & int_mask_q);
		end
	end

	// axi write channel: address and data taken in either order
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready_q <= 1'b1;
			wready_q <= 1'b1;
			bvalid_q <= 1'b0;
			bresp_q <= timer_pkg::RESP_OKAY;
			widx_q <= '0;
			wdata_q <= '0;
			wstrb_q <= '0;
		end else begin
			if (s_axi_awvalid && awready_q) begin
				widx_q <= s_axi_awaddr[7:2];
				awready_q <= 1'b0;
			end
			if (s_axi_wvalid && wready_q) begin
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
				wready_q <= 1'b0;
			end
			if (wr_go) begin
				bvalid_q <= 1'b1;
				bresp_q <= wr_resp;
				awready_q <= 1'b1;
				wready_q <= 1'b1;
			end else if (bvalid_q && s_axi_bready) begin
				bvalid_q <= 1'b0;
			end
		end
	end

	// axi read channel; active register reads while buffered are refused
	logic [31:0] rd_data;
	logic [1:0] rd_resp;
	always_comb begin
		rd_data = '0;
		rd_resp = timer_pkg::RESP_OKAY;
		case (ridx_q)
			timer_pkg::IDX_CTRL: rd_data = 32'({ctrl_q.count_mode, 1'b0, ctrl_q.enable});
			timer_pkg::IDX_CTRL_CLR, timer_pkg::IDX_CTRL_SET:
				rd_data = 32'({ctrl_q.lock_update, ctrl_q.count_down});
			timer_pkg::IDX_INT_MASK: rd_data = 32'(int_mask_q);
			timer_pkg::IDX_INT_FLAG: rd_data = 32'(int_flag_q);
			timer_pkg::IDX_STATUS, timer_pkg::IDX_SYNC_BUSY: begin
				rd_data[timer_pkg::STAT_CYCLE_VALID_BIT] = pbv_q;
				rd_data[timer_pkg::STAT_CMP_VALID_LSB +: NUM_CH] = cbv_q;
			end
			timer_pkg::IDX_DRV: rd_data = 32'(inv_q);
			timer_pkg::IDX_WAVE: rd_data = 32'(wave_q);
			timer_pkg::IDX_COUNT: rd_data = 32'(count_q);
			timer_pkg::IDX_CYCLE: begin
				rd_data = pbv_q ? '0 : 32'(cycle_q);
				rd_resp = pbv_q ? timer_pkg::RESP_SLVERR : timer_pkg::RESP_OKAY;
			end
			timer_pkg::IDX_CYCLE_BUF: rd_data = 32'(cycle_buf_q);
			default: begin
				rd_resp = timer_pkg::RESP_DECERR;
				for (int i = 0; i < NUM_CH; i++) begin
					if (ridx_q == timer_pkg::IDX_CMP0 + 6'(i)) begin
						rd_data = cbv_q[i] ? '0 : 32'(cmp_q[i]);
						rd_resp = cbv_q[i] ? timer_pkg::RESP_SLVERR : timer_pkg::RESP_OKAY;
					end
					if (ridx_q == timer_pkg::IDX_CMP_BUF0 + 6'(i)) begin
						rd_data = 32'(cmp_buf_q[i]);
						rd_resp = timer_pkg::RESP_OKAY;
					end
				end
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_q <= 1'b1;
			rvalid_q <= 1'b0;
			rdata_q <= timer_pkg::WORD_RESET;
			rresp_q <= timer_pkg::RESP_OKAY;
			ridx_q <= '0;
		end else begin
			if (s_axi_arvalid && arready_q) begin
				ridx_q <= s_axi_araddr[7:2];
				arready_q <= 1'b0;
			end else if (!arready_q && !rvalid_q) begin
				rvalid_q <= 1'b1;
				rdata_q <= rd_data;
				rresp_q <= rd_resp;
				arready_q <= 1'b1;
			end
			if (rvalid_q && s_axi_rready) begin
				rvalid_q <= 1'b0;
			end
		end
	end

	assign s_axi_awready = awready_q;
	assign s_axi_wready = wready_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_arready = arready_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;
	assign waveform_output = wo_q;
	assign capture_trigger = cap_q;
	assign overflow_event = ovf_q;
	assign irq = irq_q;

	// checks
	sequence s_hw_update;
		cbv_q[0] && upd_hw && !ctrl_q.lock_update;
	endsequence
	sequence s_freq_match;
		match[0] && !wave_q[1];
	endsequence

	a_buffer_copy: assert property (@(posedge aclk) disable iff (!aresetn)
		s_hw_update |=> !cbv_q[0] && cmp_q[0] == $past(cmp_buf_q[0]))
		else $error("buffer not copied at update point");
	a_lock_holds: assert property (@(posedge aclk) disable iff (!aresetn)
		cbv_q[0] && upd_hw && ctrl_q.lock_update && !sw_upd |=> cbv_q[0])
		else $error("locked buffer was transferred");
	a_sw_update: assert property (@(posedge aclk) disable iff (!aresetn)
		sw_upd && cbv_q[0] |=> !cbv_q[0] && cmp_q[0] == $past(cmp_buf_q[0]))
		else $error("software update command ignored");
	a_guard_error: assert property (@(posedge aclk) disable iff (!aresetn)
		wr_go && wr_map && wr_guard |=> bvalid_q && bresp_q == timer_pkg::RESP_SLVERR
			&& int_flag_q[timer_pkg::INT_ERR_BIT])
		else $error("guarded write not refused");
	a_overflow_point: assert property (@(posedge aclk) disable iff (!aresetn)
		wrap |=> ovf_q && int_flag_q[timer_pkg::INT_OVF_BIT]
			&& count_q == ($past(ctrl_q.count_down) ? $past(top) : '0))
		else $error("overflow not raised at wrap point");
	a_count_restart: assert property (@(posedge aclk) disable iff (!aresetn)
		ctrl_q.enable && !ctrl_q.count_down && count_q == top |=> count_q == '0)
		else $error("count did not restart after top");
	a_freq_toggle: assert property (@(posedge aclk) disable iff (!aresetn)
		s_freq_match |=> raw_q[0] != $past(raw_q[0]))
		else $error("frequency output did not toggle on match");
	a_pwm_clear: assert property (@(posedge aclk) disable iff (!aresetn)
		wrap && wave_q[1] |=> wo_q[0] == $past(inv_q[0]))
		else $error("pulse output not cleared at wrap");
	a_drv_locked: assert property (@(posedge aclk) disable iff (!aresetn)
		wr_go && widx_q == timer_pkg::IDX_DRV && ctrl_q.enable |=> inv_q == $past(inv_q))
		else $error("driver control changed while enabled");

endmodule

// file: pkg/timer_pkg.sv
// constants, field layouts and carrier types of the waveform timer
// assumes one 32-bit AXI4-Lite register space, each register one aligned word
package timer_pkg;

	// register indices; byte address is four times the index
	localparam logic [5:0] IDX_CTRL = 6'h00;
	localparam logic [5:0] IDX_CTRL_CLR = 6'h04;
	localparam logic [5:0] IDX_CTRL_SET = 6'h05;
	localparam logic [5:0] IDX_INT_MASK = 6'h08;
	localparam logic [5:0] IDX_INT_FLAG = 6'h0A;
	localparam logic [5:0] IDX_STATUS = 6'h0B;
	localparam logic [5:0] IDX_DRV = 6'h0D;
	localparam logic [5:0] IDX_WAVE = 6'h0E;
	localparam logic [5:0] IDX_SYNC_BUSY = 6'h0F;
	localparam logic [5:0] IDX_COUNT = 6'h14;
	localparam logic [5:0] IDX_CMP0 = 6'h18;
	localparam logic [5:0] IDX_CYCLE = 6'h1B;
	localparam logic [5:0] IDX_CMP_BUF0 = 6'h1C;
	localparam logic [5:0] IDX_CYCLE_BUF = 6'h2F;

	// control word fields
	localparam int CTRL_ENABLE_BIT = 0;
	localparam int CTRL_MODE_LSB = 2;
	localparam int CTRLB_DOWN_BIT = 0;
	localparam int CTRLB_LOCK_BIT = 1;
	localparam int CTRLB_CMD_LSB = 5;
	localparam logic [2:0] CMD_UPDATE = 3'h3;

	// interrupt flag / mask and status layouts
	localparam int INT_OVF_BIT = 0;
	localparam int INT_ERR_BIT = 1;
	localparam int INT_MATCH_LSB = 4;
	localparam int STAT_CYCLE_VALID_BIT = 0;
	localparam int STAT_CMP_VALID_LSB = 4;

	// reset values
	localparam logic [7:0] DRV_RESET = 8'h00;
	localparam logic [7:0] WAVE_RESET = 8'h00;
	localparam logic [31:0] WORD_RESET = 32'h0000_0000;

	// AXI response codes
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [1:0] RESP_DECERR = 2'h3;

	typedef enum logic [1:0] {
		normal_frequency = 2'h0,
		match_frequency = 2'h1,
		normal_pulse_width = 2'h2,
		match_pulse_width = 2'h3
	} waveform_select_t;

	typedef enum logic [1:0] {
		count_16 = 2'h0,
		count_8 = 2'h1,
		count_32 = 2'h2,
		count_rsvd = 2'h3
	} count_mode_t;

	typedef struct packed {
		logic lock_update;
		logic count_down;
		count_mode_t count_mode;
		logic enable;
	} ctrl_t;

endpackage

// file: dv/wave_load.sv
// load on the waveform pins: counts high samples and edges per channel, and
// drives the capture trigger pins with levels the bench chooses
// assumes clear is driven synchronous to clk by the bench
`timescale 1ns/100ps
module wave_load #(
	parameter int N = 2
) (
	// clock
	input wire logic clk,
	// pins
	input wire logic [N-1:0] wave,
	output logic [N-1:0] sense_out,
	// bench control
	input wire logic clear,
	input wire logic [N-1:0] sense_set,
	output logic [N-1:0][15:0] high_cnt,
	output logic [N-1:0][15:0] edge_cnt
);
	logic [N-1:0] last_q;

	// a sensor level is held steady, so a plain follow is enough
	assign sense_out = sense_set;

	// edges are counted against the previous sample, so a window of one period
	// sees every transition exactly once whatever its phase
	always @(posedge clk) begin
		last_q <= wave;
		for (int i = 0; i < N; i++) begin
			high_cnt[i] <= clear ? 16'h0000 : high_cnt[i] + 16'(wave[i]);
			edge_cnt[i] <= clear ? 16'h0000 : edge_cnt[i] + 16'(wave[i] ^ last_q[i]);
		end
	end
endmodule

// file: dv/testbench.sv
// self-checking bench for the waveform timer: register bus, waveforms, buffers, interrupt
// assumes the timer package is compiled first and the pin load model beside it
`timescale 1ns/100ps
module testbench;
	localparam logic [1:0] ok = timer_pkg::RESP_OKAY;
	localparam logic [1:0] se = timer_pkg::RESP_SLVERR;
	localparam logic [5:0] cmp1 = timer_pkg::IDX_CMP0 + 6'h01;
	localparam logic [5:0] buf1 = timer_pkg::IDX_CMP_BUF0 + 6'h01;
	logic aclk = 1'h0;
	logic aresetn = 1'h0;
	logic [7:0] awaddr = 8'h00;
	logic [7:0] araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic awvalid = 1'h0;
	logic wvalid = 1'h0;
	logic bready = 1'h0;
	logic arvalid = 1'h0;
	logic rready = 1'h0;
	logic guard = 1'h0;
	logic clr = 1'h1;
	logic [1:0] sense = 2'h0;
	logic awready, wready, bvalid, arready, rvalid, ovf, irq;
	logic [1:0] bresp, rresp, cap_in, wave, cap;
	logic [31:0] rdata;
	logic [1:0][15:0] high_cnt, edge_cnt;
	int n_fail = 0;
	int compares = 0;
	int seed = 32'h92DB;

	always #20 aclk = ~aclk;

	timer_waveform_double_buffer #(.NUM_CH(2), .CW(32)) DUT (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.access_guard(guard), .capture_trigger_in(cap_in), .waveform_output(wave),
		.capture_trigger(cap), .overflow_event(ovf), .irq(irq));

	wave_load #(.N(2)) load (.clk(aclk), .wave(wave), .sense_out(cap_in), .clear(clr),
		.sense_set(sense), .high_cnt(high_cnt), .edge_cnt(edge_cnt));

	task automatic test_done();
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// each task starts one edge later so a released strobe is never raised in the same step
	task automatic wr(input logic [5:0] idx, input logic [31:0] d, input logic [1:0] er);
		logic aw_ok;
		logic w_ok;
		aw_ok = 1'h0;
		w_ok = 1'h0;
		@(posedge aclk);
		awaddr <= {idx, 2'h0};
		wdata <= d;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		while (!(aw_ok && w_ok)) begin
			@(posedge aclk);
			if (awvalid && awready) begin
				aw_ok = 1'h1;
				awvalid <= 1'h0;
			end
			if (wvalid && wready) begin
				w_ok = 1'h1;
				wvalid <= 1'h0;
			end
		end
		while (bvalid !== 1'h1)
			@(posedge aclk);
		bready <= 1'h0;
		chk($sformatf("write response at %h", idx), {30'h0, bresp}, {30'h0, er});
	endtask

	task automatic rd(input logic [5:0] idx, input logic [31:0] exp, input logic [1:0] er);
		@(posedge aclk);
		araddr <= {idx, 2'h0};
		arvalid <= 1'h1;
		rready <= 1'h1;
		do
			@(posedge aclk);
		while (!(arvalid && arready));
		arvalid <= 1'h0;
		while (rvalid !== 1'h1)
			@(posedge aclk);
		rready <= 1'h0;
		chk($sformatf("read data at %h", idx), rdata, exp);
		chk($sformatf("read response at %h", idx), {30'h0, rresp}, {30'h0, er});
	endtask

	// bounded: a count above top runs through the whole 8-bit range first
	task automatic wait_ovf(output int n);
		n = 0;
		do begin
			@(posedge aclk);
			n++;
		end while (ovf !== 1'h1 && n < 600);
	endtask

	function automatic logic [31:0] exp_edges(input logic [1:0] m, input int top, input int c);
		if (!m[1])
			return 32'h1;
		return (c >= top) ? 32'h0 : 32'h2;
	endfunction

	// wrap beats a match landing on top, so such a channel stays low
	function automatic logic [31:0] exp_high(input int top, input int c, input logic inv);
		int h;
		h = (c >= top) ? 0 : top - c;
		return inv ? 32'(top + 1 - h) : 32'(h);
	endfunction

	initial begin
		#2000000;
		n_fail++;
		test_done();
	end

	initial begin
		logic [1:0] m;
		logic [1:0] inv;
		int top, c0, c1, n;
		repeat (16) @(posedge aclk);
		aresetn <= 1'h1;
		rd(timer_pkg::IDX_DRV, {24'h0, timer_pkg::DRV_RESET}, ok);
		rd(timer_pkg::IDX_WAVE, {24'h0, timer_pkg::WAVE_RESET}, ok);
		rd(6'h3F, 32'h0, timer_pkg::RESP_DECERR);
		wr(6'h3E, 32'h1, timer_pkg::RESP_DECERR);
		for (int k = 0; k < 8; k++) begin
			m = 2'(k);
			inv = 2'($random(seed));
			sense <= 2'($random(seed));
			top = 10 + $unsigned($random(seed)) % 30;
			c0 = m[0] ? top : $unsigned($random(seed)) % top;
			c1 = $unsigned($random(seed)) % top;
			wr(timer_pkg::IDX_WAVE, {30'h0, m}, ok);
			wr(timer_pkg::IDX_DRV, {30'h0, inv}, ok);
			wr(timer_pkg::IDX_CYCLE, top, ok);
			wr(timer_pkg::IDX_CMP0, c0, ok);
			wr(cmp1, c1, ok);
			wr(timer_pkg::IDX_CTRL, 32'h5, ok); // enable, 8-bit count
			rd(timer_pkg::IDX_SYNC_BUSY, 32'h0, ok);
			rd(timer_pkg::IDX_WAVE, {30'h0, m}, ok);
			chk("capture trigger", {30'h0, cap}, {30'h0, sense ^ inv});
			wait_ovf(n);
			wait_ovf(n);
			chk("period", n, top + 1);
			clr <= 1'h1;
			@(posedge aclk);
			clr <= 1'h0;
			repeat (top + 1) @(posedge aclk);
			#1;
			chk("edges ch0", {16'h0, edge_cnt[0]}, exp_edges(m, top, c0));
			chk("edges ch1", {16'h0, edge_cnt[1]}, exp_edges(m, top, c1));
			if (m[1]) begin
				chk("high ch0", {16'h0, high_cnt[0]}, exp_high(top, c0, inv[0]));
				chk("high ch1", {16'h0, high_cnt[1]}, exp_high(top, c1, inv[1]));
			end
			wr(timer_pkg::IDX_CTRL, 32'h0, ok);
		end
		wr(timer_pkg::IDX_WAVE, 32'h2, ok);
		wr(timer_pkg::IDX_CYCLE, 32'd20, ok);
		wr(timer_pkg::IDX_CTRL, 32'h5, ok);
		wr(timer_pkg::IDX_CTRL_SET, 32'h2, ok);
		rd(timer_pkg::IDX_CTRL_SET, 32'h2, ok);
		wr(buf1, 32'h7, ok);
		rd(timer_pkg::IDX_STATUS, 32'h20, ok);
		rd(timer_pkg::IDX_SYNC_BUSY, 32'h20, ok);
		wr(cmp1, 32'h3, se);
		wr(buf1, 32'h3, se);
		rd(cmp1, 32'h0, se);
		wait_ovf(n);
		wait_ovf(n);
		rd(timer_pkg::IDX_STATUS, 32'h20, ok);
		wr(timer_pkg::IDX_CTRL_SET, {24'h0, timer_pkg::CMD_UPDATE, 5'h00}, ok);
		wait_ovf(n);
		repeat (2) @(posedge aclk);
		rd(timer_pkg::IDX_STATUS, 32'h0, ok);
		rd(cmp1, 32'h7, ok);
		wr(timer_pkg::IDX_CYCLE_BUF, 32'd12, ok);
		rd(timer_pkg::IDX_STATUS, 32'h1, ok);
		rd(timer_pkg::IDX_CYCLE, 32'h0, se);
		wr(timer_pkg::IDX_CTRL_CLR, 32'h2, ok);
		wait_ovf(n);
		repeat (2) @(posedge aclk);
		rd(timer_pkg::IDX_STATUS, 32'h0, ok);
		rd(timer_pkg::IDX_CYCLE, 32'd12, ok);
		wait_ovf(n);
		wait_ovf(n);
		chk("period after update", n, 13);
		wr(timer_pkg::IDX_CTRL_SET, 32'h1, ok);
		wait_ovf(n);
		wait_ovf(n);
		chk("period counting down", n, 13);
		wr(timer_pkg::IDX_CTRL_CLR, 32'h1, ok);
		wr(timer_pkg::IDX_DRV, {30'h0, ~inv}, ok);
		rd(timer_pkg::IDX_DRV, {30'h0, inv}, ok);
		// 16-bit and 32-bit counts ignore the cycle length, so no wrap within the bound
		wr(timer_pkg::IDX_CTRL, 32'h1, ok);
		wr(timer_pkg::IDX_CYCLE_BUF, 32'd5, ok);
		rd(timer_pkg::IDX_STATUS, 32'h0, ok);
		wait_ovf(n);
		chk("no wrap at cycle length 16-bit", n, 600);
		wr(timer_pkg::IDX_CTRL, 32'h9, ok);
		wait_ovf(n);
		chk("no wrap at cycle length 32-bit", n, 600);
		wr(timer_pkg::IDX_CTRL, 32'h0, ok);
		wr(timer_pkg::IDX_INT_FLAG, 32'hFF, ok);
		guard <= 1'h1;
		wr(timer_pkg::IDX_DRV, {30'h0, ~inv}, se);
		guard <= 1'h0;
		rd(timer_pkg::IDX_DRV, {30'h0, inv}, ok);
		rd(timer_pkg::IDX_INT_FLAG, 32'h2, ok);
		chk("irq masked", {31'h0, irq}, 32'h0);
		wr(timer_pkg::IDX_INT_MASK, 32'h2, ok);
		repeat (2) @(posedge aclk);
		#1;
		chk("irq unmasked", {31'h0, irq}, 32'h1);
		wr(timer_pkg::IDX_INT_FLAG, 32'h2, ok);
		repeat (2) @(posedge aclk);
		#1;
		chk("irq cleared", {31'h0, irq}, 32'h0);
		test_done();
	end
endmodule
